// file: hw/csp_byte_reg.v
// Purpose: one 8-bit register with byte write and single-bit write
// Assumes: bit and byte writes never occur in the same cycle
// Notes: byte write wins if both are raised
`timescale 1ns/1ps
module csp_byte_reg #(
    parameter [7:0] RST_VAL = 8'h00
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Byte write
    input wire byte_we,
    input wire [7:0] byte_d,
    // Bit write
    input wire bit_we,
    input wire [2:0] bit_sel,
    input wire bit_val,
    // Stored value
    output reg [7:0] val_q
);
    // ------------------------------------------------
    // Storage
    // ------------------------------------------------
    // Byte or single-bit update
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            val_q <= RST_VAL;
        end
        else if (byte_we)
        begin
            val_q <= byte_d;
        end
        else if (bit_we)
        begin
            val_q[bit_sel] <= bit_val;
        end
    end
endmodule // csp_byte_reg

// file: hw/csp_consts.vh
// Purpose: constants for the core status and pointer registers
// Assumes: 8-bit special register space, byte-wide registers
// Notes: offsets are special-register addresses
`ifndef CSP_CONSTS_VH
`define CSP_CONSTS_VH
// Register addresses
`define CSP_ADDR_STACK_POINTER 8'h81
`define CSP_ADDR_POINTER_LOW 8'h82
`define CSP_ADDR_POINTER_HIGH 8'h83
`define CSP_ADDR_STATUS_WORD 8'hD0
`define CSP_ADDR_MAIN_WORK 8'hE0
`define CSP_ADDR_AUX_WORK 8'hF0
// Reserved addresses
`define CSP_ADDR_RSVD_0 8'h97
`define CSP_ADDR_RSVD_1 8'hA2
`define CSP_ADDR_RSVD_2 8'hB3
`define CSP_ADDR_RSVD_3 8'hB4
`define CSP_ADDR_RSVD_4 8'hCE
`define CSP_ADDR_RSVD_5 8'hDF
// Reset values
`define CSP_RST_STACK_POINTER 8'h07
`define CSP_RST_STATUS_WORD 8'h00
`define CSP_RST_MAIN_WORK 8'h00
`define CSP_RST_AUX_WORK 8'h00
`define CSP_RST_POINTER 8'h00
// Status word bit positions
`define CSP_BIT_CARRY 7
`define CSP_BIT_HALF_CARRY 6
`define CSP_BIT_USER_A 5
`define CSP_BIT_BANK_HIGH 4
`define CSP_BIT_BANK_LOW 3
`define CSP_BIT_RANGE 2
`define CSP_BIT_USER_B 1
`define CSP_BIT_ODD_ONES 0
// Bank base address shift (eight registers per bank)
`define CSP_BANK_SHIFT 3
`endif

// file: hw/csp_core_regs.v
// Purpose: stack pointer, data pointer, status word and work registers
// Assumes: core issues at most one access of each kind per cycle
// Notes: special register port is byte and bit addressed
// Notes on behaviour
// - stack pointer resets to 0x07
// - push: increment pointer, then write there
// - data pointer is high byte, low byte
// - data pointer addresses external and program memory
// - carry bit 7 set on carry/borrow
// - half carry bit 6 on nibble carry
// - range bit 2 on carry/borrow/mul-div overflow
// - arithmetic clears unmet flags
// - bit 0 is odd-ones of main register
// - bits 4..3 select working register bank
// - bits 5 and 1 software-only flags
// - main register resets zero, arithmetic result
// - aux register second operand for mul/div
// - reserved addresses have no register
`timescale 1ns/1ps
`include "csp_consts.vh"
module csp_core_regs (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Special register byte port
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    output wire sfr_hit,
    // Special register bit port (address of byte, bit index)
    input wire [7:0] bit_addr,
    input wire [2:0] bit_idx,
    input wire bit_wr,
    input wire bit_wval,
    output wire bit_rval,
    // Arithmetic result from the execution unit
    input wire arith_done,
    input wire [7:0] arith_main,
    input wire arith_main_we,
    input wire [7:0] arith_aux,
    input wire arith_aux_we,
    input wire arith_carry,
    input wire arith_half_carry,
    input wire arith_range,
    // Stack operations
    input wire push_req,
    input wire pop_req,
    output reg stack_wr,
    output reg [7:0] stack_wr_addr,
    output reg [7:0] stack_wr_data,
    input wire [7:0] push_data,
    // Data pointer increment
    input wire data_pointer_inc,
    // Derived views
    output wire [15:0] data_pointer,
    output wire [7:0] stack_pointer,
    output wire [4:0] bank_base,
    output wire [7:0] program_status_word,
    output wire [7:0] main_work_register,
    output wire [7:0] aux_work_register
);
    // ------------------------------------------------
    // Reset release
    // ------------------------------------------------
    reg rst_s1_q; // First stage
    reg rst_s2_q; // Synchronised reset, active low

    // Two-flop release of the asynchronous reset
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    // ------------------------------------------------
    // Address decode
    // ------------------------------------------------
    wire wr_sp = sfr_wr && (sfr_addr == `CSP_ADDR_STACK_POINTER);
    wire wr_dl = sfr_wr && (sfr_addr == `CSP_ADDR_POINTER_LOW);
    wire wr_dh = sfr_wr && (sfr_addr == `CSP_ADDR_POINTER_HIGH);
    wire wr_sw = sfr_wr && (sfr_addr == `CSP_ADDR_STATUS_WORD);
    wire wr_mw = sfr_wr && (sfr_addr == `CSP_ADDR_MAIN_WORK);
    wire wr_aw = sfr_wr && (sfr_addr == `CSP_ADDR_AUX_WORK);
    // Bit writes reach only the bit-addressable registers
    wire bw_sw = bit_wr && (bit_addr == `CSP_ADDR_STATUS_WORD);
    wire bw_mw = bit_wr && (bit_addr == `CSP_ADDR_MAIN_WORK);
    wire bw_aw = bit_wr && (bit_addr == `CSP_ADDR_AUX_WORK);

    // ------------------------------------------------
    // Stack pointer
    // ------------------------------------------------
    reg [7:0] sp_q; // Stack pointer
    reg [7:0] sp_d; // Next stack pointer
    wire [7:0] sp_inc = sp_q + 8'h01; // Pre-incremented location

    // Next pointer: software write beats push or pop
    always @*
    begin
        sp_d = sp_q;
        if (wr_sp)
        begin
            sp_d = sfr_wdata;
        end
        else if (push_req)
        begin
            sp_d = sp_inc;
        end
        else if (pop_req)
        begin
            sp_d = sp_q - 8'h01;
        end
    end

    // Pointer storage
    always @(posedge clk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            sp_q <= `CSP_RST_STACK_POINTER;
        end
        else
        begin
            sp_q <= sp_d;
        end
    end

    // Push write goes to the incremented location, not the old one
    always @(posedge clk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            stack_wr <= 1'b0;
            stack_wr_addr <= 8'h00;
            stack_wr_data <= 8'h00;
        end
        else
        begin
            stack_wr <= push_req && !wr_sp;
            if (push_req && !wr_sp)
            begin
                stack_wr_addr <= sp_inc;
                stack_wr_data <= push_data;
            end
        end
    end

    // ------------------------------------------------
    // Data pointer
    // ------------------------------------------------
    reg [7:0] dpl_q; // Pointer low byte
    reg [7:0] dph_q; // Pointer high byte
    wire [15:0] data_pointer_next = {dph_q, dpl_q} + 16'h0001;

    // Byte writes, or a 16-bit increment from the core
    always @(posedge clk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            dpl_q <= `CSP_RST_POINTER;
            dph_q <= `CSP_RST_POINTER;
        end
        else
        begin
            if (wr_dl)
            begin
                dpl_q <= sfr_wdata;
            end
            else if (data_pointer_inc)
            begin
                dpl_q <= data_pointer_next[7:0];
            end
            if (wr_dh)
            begin
                dph_q <= sfr_wdata;
            end
            else if (data_pointer_inc)
            begin
                dph_q <= data_pointer_next[15:8];
            end
        end
    end

    // High byte above low byte; used for external and program memory
    assign data_pointer = {dph_q, dpl_q};

    // ------------------------------------------------
    // Main and auxiliary work registers
    // ------------------------------------------------
    wire [7:0] mw_q; // Main work register
    wire [7:0] aw_q; // Aux work register

    // Main register: software byte write beats arithmetic result
    csp_byte_reg #(
        .RST_VAL(`CSP_RST_MAIN_WORK)
    ) u_main (
        .clk(clk),
        .rst_n(rst_s2_q),
        .byte_we(wr_mw || arith_main_we),
        .byte_d(wr_mw ? sfr_wdata : arith_main),
        .bit_we(bw_mw),
        .bit_sel(bit_idx),
        .bit_val(bit_wval),
        .val_q(mw_q)
    );

    // Aux register holds second operand / result of multiply, divide
    csp_byte_reg #(
        .RST_VAL(`CSP_RST_AUX_WORK)
    ) u_aux (
        .clk(clk),
        .rst_n(rst_s2_q),
        .byte_we(wr_aw || arith_aux_we),
        .byte_d(wr_aw ? sfr_wdata : arith_aux),
        .bit_we(bw_aw),
        .bit_sel(bit_idx),
        .bit_val(bit_wval),
        .val_q(aw_q)
    );

    // ------------------------------------------------
    // Program status word
    // ------------------------------------------------
    reg [7:0] sw_q; // Stored bits 7..1; bit 0 unused
    reg [7:0] sw_d; // Next stored bits

    // Software writes first, then arithmetic flags override
    always @*
    begin
        sw_d = sw_q;
        if (wr_sw)
        begin
            sw_d = sfr_wdata;
        end
        else if (bw_sw)
        begin
            sw_d[bit_idx] = bit_wval;
        end
        if (arith_done)
        begin
            // Each flag set on its condition, cleared otherwise
            sw_d[`CSP_BIT_CARRY] = arith_carry;
            sw_d[`CSP_BIT_HALF_CARRY] = arith_half_carry;
            sw_d[`CSP_BIT_RANGE] = arith_range;
        end
        // Odd-ones bit is never stored; writes are dropped
        sw_d[`CSP_BIT_ODD_ONES] = 1'b0;
    end

    // Status storage; user flags only change through software paths
    always @(posedge clk or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            sw_q <= `CSP_RST_STATUS_WORD;
        end
        else
        begin
            sw_q <= sw_d;
        end
    end

    // Odd-ones bit follows the main register every cycle
    wire odd_ones = ^mw_q;
    assign program_status_word = {sw_q[7:1], odd_ones};

    // Bank base address: bank number times eight
    assign bank_base = {sw_q[`CSP_BIT_BANK_HIGH:`CSP_BIT_BANK_LOW], 3'h0};

    // ------------------------------------------------
    // Read path
    // ------------------------------------------------
    // Byte read mux; reserved and unknown addresses miss and read zero
    always @*
    begin
        case (sfr_addr)
            `CSP_ADDR_STACK_POINTER: sfr_rdata = sp_q;
            `CSP_ADDR_POINTER_LOW: sfr_rdata = dpl_q;
            `CSP_ADDR_POINTER_HIGH: sfr_rdata = dph_q;
            `CSP_ADDR_STATUS_WORD: sfr_rdata = program_status_word;
            `CSP_ADDR_MAIN_WORK: sfr_rdata = mw_q;
            `CSP_ADDR_AUX_WORK: sfr_rdata = aw_q;
            default: sfr_rdata = 8'h00;
        endcase
    end

    // Hit only for implemented registers
    assign sfr_hit = (sfr_addr == `CSP_ADDR_STACK_POINTER) ||
                     (sfr_addr == `CSP_ADDR_POINTER_LOW) ||
                     (sfr_addr == `CSP_ADDR_POINTER_HIGH) ||
                     (sfr_addr == `CSP_ADDR_STATUS_WORD) ||
                     (sfr_addr == `CSP_ADDR_MAIN_WORK) ||
                     (sfr_addr == `CSP_ADDR_AUX_WORK);

    // Bit read from the bit-addressable registers
    reg [7:0] bit_src; // Selected byte for bit read

    // Bit source mux
    always @*
    begin
        case (bit_addr)
            `CSP_ADDR_STATUS_WORD: bit_src = program_status_word;
            `CSP_ADDR_MAIN_WORK: bit_src = mw_q;
            `CSP_ADDR_AUX_WORK: bit_src = aw_q;
            default: bit_src = 8'h00;
        endcase
    end

    assign bit_rval = bit_src[bit_idx];

    // ------------------------------------------------
    // Direct views
    // ------------------------------------------------
    assign stack_pointer = sp_q;
    assign main_work_register = mw_q;
    assign aux_work_register = aw_q;
endmodule // csp_core_regs

// file: verif/csp_core_regs_sva.sv
// Purpose: port-level checks of the core status and pointer registers
// Assumes: single clock, checks idle while nrst is low
// Notes: bound to every instance of the register block
`timescale 1ns/1ps
module csp_core_regs_sva (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Requests
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] bit_addr,
    input wire bit_wr,
    input wire arith_done,
    input wire arith_carry,
    input wire arith_half_carry,
    input wire arith_range,
    input wire push_req,
    input wire [7:0] push_data,
    // Observed state
    input wire [7:0] sfr_rdata,
    input wire sfr_hit,
    input wire stack_wr,
    input wire [7:0] stack_wr_addr,
    input wire [7:0] stack_wr_data,
    input wire [15:0] data_pointer,
    input wire [7:0] stack_pointer,
    input wire [4:0] bank_base,
    input wire [7:0] program_status_word,
    input wire [7:0] main_work_register
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    reg [7:0] sp_next_q; // Pointer plus one, wraps at 8 bits
    wire sp_wr = sfr_wr && sfr_addr == 8'h81; // Software pointer write
    // Byte or bit write aimed at the status word itself
    wire psw_wr = (sfr_wr && sfr_addr == 8'hD0) || (bit_wr && bit_addr == 8'hD0);
    // Track the expected pointer after a push
    always @(posedge clk)
    begin
        sp_next_q <= stack_pointer + 8'h01;
    end
    sequence s_push_out;
        stack_wr && stack_wr_addr == stack_pointer && stack_pointer == sp_next_q;
    endsequence
    a_sp_reset_val: assert property ($rose(nrst) |-> stack_pointer == 8'h07)
        else $error("stack pointer not 0x07 after reset");
    a_push_pre_inc: assert property (push_req && !sp_wr |=> s_push_out)
        else $error("push did not write at incremented pointer");
    a_push_byte: assert property (push_req && !sp_wr |=> stack_wr_data == $past(push_data))
        else $error("pushed byte wrong");
    a_ptr_bytes: assert property (sfr_addr == 8'h83 |-> sfr_rdata == data_pointer[15:8])
        else $error("pointer high byte not bits 15..8");
    a_arith_flags: assert property (arith_done |=> program_status_word[7] == $past(arith_carry)
        && program_status_word[6] == $past(arith_half_carry)
        && program_status_word[2] == $past(arith_range))
        else $error("arithmetic flags not loaded");
    a_odd_ones: assert property (program_status_word[0] == ^main_work_register)
        else $error("odd-ones bit wrong");
    a_bank_map: assert property (bank_base == {program_status_word[4:3], 3'b000})
        else $error("bank base wrong");
    a_user_keep: assert property (!psw_wr |=> $stable(program_status_word[5])
        && $stable(program_status_word[1]))
        else $error("user flag changed by hardware");
    a_rsvd_none: assert property (sfr_addr inside {8'h97, 8'hA2, 8'hB3, 8'hB4, 8'hCE, 8'hDF}
        |-> !sfr_hit && sfr_rdata == 8'h00)
        else $error("reserved address answered");
endmodule // csp_core_regs_sva
bind csp_core_regs csp_core_regs_sva u_sva (.clk, .nrst, .sfr_addr, .sfr_wr, .bit_addr,
    .bit_wr, .arith_done, .arith_carry, .arith_half_carry, .arith_range, .push_req,
    .push_data, .sfr_rdata, .sfr_hit, .stack_wr, .stack_wr_addr, .stack_wr_data,
    .data_pointer, .stack_pointer, .bank_base, .program_status_word, .main_work_register);

// file: verif/csp_core_regs_tb.sv
// Purpose: directed bench for the core status and pointer registers
// Assumes: inputs change on the falling edge, reads are combinational
// Notes: strobes are pulsed one cycle through task hw
`timescale 1ns/1ps
module csp_core_regs_tb;
    reg clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, bit_wr = 1'b0, bit_wval = 1'b0;
    reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00, push_data = 8'h00;
    reg [7:0] arith_main = 8'h00, arith_aux = 8'h00;
    reg [2:0] bit_idx = 3'h0;
    reg arith_done = 1'b0, arith_main_we = 1'b0, arith_aux_we = 1'b0, push_req = 1'b0;
    reg pop_req = 1'b0, data_pointer_inc = 1'b0, arith_carry = 1'b0, arith_half_carry = 1'b0;
    reg arith_range = 1'b0;
    wire [7:0] sfr_rdata, stack_wr_addr, stack_wr_data, stack_pointer;
    wire [7:0] program_status_word, main_work_register, aux_work_register;
    wire [15:0] data_pointer;
    wire [4:0] bank_base;
    wire sfr_hit, bit_rval, stack_wr;
    logic [7:0] rsvd [6] = '{8'h97, 8'hA2, 8'hB3, 8'hB4, 8'hCE, 8'hDF}; // Empty slots
    integer err_total = 0, n_compared = 0, i;
    always #2 clk = ~clk;
    csp_core_regs DUT (.clk, .nrst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .sfr_hit,
        .bit_addr, .bit_idx, .bit_wr, .bit_wval, .bit_rval, .arith_done, .arith_main,
        .arith_main_we, .arith_aux, .arith_aux_we, .arith_carry, .arith_half_carry,
        .arith_range, .push_req, .pop_req, .stack_wr, .stack_wr_addr, .stack_wr_data,
        .push_data, .data_pointer_inc, .data_pointer, .stack_pointer, .bank_base,
        .program_status_word, .main_work_register, .aux_work_register);
    csp_stack_model u_stk (.clk, .stack_wr, .stack_wr_addr, .stack_wr_data);
    // Compare and count
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
        n_compared = n_compared + 1;
        if (seen !== exp)
        begin
            err_total = err_total + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    // One byte write, strobe high for one edge
    task wr(input [7:0] a, input [7:0] d);
    begin
        @(negedge clk);
        {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge clk);
        sfr_wr = 1'b0;
    end
    endtask
    // Address set on the falling edge, combinational data looked at 1 ns later
    task rd(input [7:0] a, input [7:0] exp, input string nm);
    begin
        @(negedge clk);
        sfr_addr = a;
        #1 chk(nm, sfr_rdata, exp);
    end
    endtask
    // Pulse hardware strobes: done, main, aux, push, pop, inc, bit
    task hw(input [6:0] s);
    begin
        @(negedge clk);
        {arith_done, arith_main_we, arith_aux_we, push_req, pop_req, data_pointer_inc, bit_wr} = s;
        @(negedge clk);
        {arith_done, arith_main_we, arith_aux_we, push_req, pop_req, data_pointer_inc, bit_wr} = 7'h00;
    end
    endtask
    task wrap_up;
    begin
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    // Cut a hang short
    initial
    begin
        repeat (2000) @(posedge clk);
        err_total = err_total + 1;
        wrap_up;
    end
    initial
    begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'h81, 8'h07, "sp");
        chk("hit sp", sfr_hit, 1'b1);
        chk("bit none", bit_rval, 1'b0);
        rd(8'hE0, 8'h00, "main");
        rd(8'hF0, 8'h00, "aux");
        $display("reset test done");
        push_data = 8'hAA;
        hw(7'h08);
        push_data = 8'h55;
        hw(7'h08);
        chk("sp push", stack_pointer, 8'h09);
        hw(7'h04);
        chk("sp pop", stack_pointer, 8'h08);
        chk("stk8", u_stk.mem[8], 8'hAA);
        chk("stk9", u_stk.mem[9], 8'h55);
        $display("stack test done");
        wr(8'h82, 8'hFF);
        wr(8'h83, 8'h12);
        chk("data_pointer", data_pointer, 16'h12FF);
        hw(7'h02);
        chk("data_pointer inc", data_pointer, 16'h1300);
        $display("pointer test done");
        {arith_carry, arith_half_carry, arith_range, arith_main} = {3'b111, 8'h07};
        hw(7'h60);
        rd(8'hD0, 8'hC5, "psw set");
        {arith_carry, arith_half_carry, arith_range, arith_main} = {3'b000, 8'h03};
        arith_aux = 8'h5A;
        hw(7'h70);
        rd(8'hD0, 8'h00, "psw clr");
        rd(8'hF0, 8'h5A, "aux");
        chk("aux out", aux_work_register, 8'h5A);
        wr(8'hD0, 8'h01);
        rd(8'hD0, 8'h00, "odd wr");
        $display("flag test done");
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(8'hD0, {3'b000, i[1:0], 3'b000});
            chk("bank", bank_base, {i[1:0], 3'b000});
        end
        {bit_addr, bit_idx, bit_wval} = {8'hD0, 3'h5, 1'b1};
        hw(7'h01);
        bit_idx = 3'h1;
        hw(7'h01);
        hw(7'h40);
        rd(8'hD0, 8'h3A, "user");
        chk("bit read", bit_rval, 1'b1);
        {bit_addr, bit_idx} = {8'hE0, 3'h7};
        hw(7'h01);
        rd(8'hE0, 8'h83, "bit main");
        chk("odd", program_status_word[0], 1'b1);
        chk("main out", main_work_register, 8'h83);
        $display("bit test done");
        for (i = 0; i < 6; i = i + 1)
        begin
            wr(rsvd[i], 8'h00);
            rd(rsvd[i], 8'h00, "rsvd");
            chk("hit", sfr_hit, 1'b0);
        end
        $display("reserved test done");
        // Mid-run reset: pointer and main register must return to reset values
        @(negedge clk);
        nrst = 1'b0;
        #1 chk("sp async", stack_pointer, 8'h07);
        @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        rd(8'h81, 8'h07, "sp again");
        rd(8'hE0, 8'h00, "main again");
        $display("reset again test done");
        wrap_up;
    end
endmodule // csp_core_regs_tb

// file: verif/csp_stack_model.sv
// Purpose: stack memory that sits behind the core's stack write port
// Assumes: one stack write per cycle at most
// Notes: the bench reads mem directly to see what was pushed
`timescale 1ns/1ps
module csp_stack_model (
    // Clock
    input wire clk,
    // Stack write port
    input wire stack_wr,
    input wire [7:0] stack_wr_addr,
    input wire [7:0] stack_wr_data
);
    reg [7:0] mem [0:255]; // Internal stack area
    // Store each pushed byte where the pointer says
    always @(posedge clk)
    begin
        if (stack_wr)
            mem[stack_wr_addr] <= stack_wr_data;
    end
endmodule // csp_stack_model
